//--- core/pmr_pkg.sv
package pmr_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses are four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] WDOG_PRESCALE_IDX = 8'h09;
  localparam logic [7:0] PROC_STATUS_IDX = 8'h0a;
  localparam logic [7:0] MODE_CTRL_IDX = 8'h26;
  localparam logic [7:0] PORT_DATA_IDX = 8'h12;
  localparam logic [7:0] PORT_DIR_IDX = 8'h13;
  localparam logic [7:0] WAKE_CTRL_IDX = 8'h40;
  localparam logic [7:0] CORE_STAT_IDX = 8'h41;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FAST_CLK_BIT = 7;
  localparam int OSC_OFF_BIT = 6;
  localparam int UP_EN_BIT = 5;
  localparam int TIMEOUT_BIT = 5;
  localparam int PWRDN_BIT = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] WDOG_PRESCALE_RST = 8'h07;
  localparam logic [7:0] MODE_CTRL_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [7:0] WAKE_MASK_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int STARTUP_CYCLES = 1024;
  localparam int WDOG_BASE_DIV = 512;
  localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_CYCLES - 1);

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_GREEN, ST_NORMAL, ST_SLEEP, ST_IDLE, ST_START
  } pm_state_t;

endpackage : pmr_pkg

//--- core/startup_counter.sv
`timescale 1ns/1ps
module startup_counter
  import pmr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // control
  input wire logic start_in,
  input wire logic tick_in,
  // status
  output logic busy_out,
  output logic done_out
);

  logic [10:0] count_r;

  // counts restarted-oscillator clock ticks up to terminal count
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_r <= '0;
      busy_out <= 1'b1;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        count_r <= '0;
        busy_out <= 1'b1;
      end else if (busy_out && tick_in) begin
        if (count_r == STARTUP_LAST) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count_r <= count_r + 11'h001;
        end
      end
    end
  end

endmodule : startup_counter

//--- core/clock_glitch_free_mux.sv
`timescale 1ns/1ps
module clock_glitch_free_mux (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // source ticks
  input wire logic slow_tick_in,
  input wire logic fast_tick_in,
  input wire logic want_fast_in,
  input wire logic run_in,
  // selected tick
  output logic sys_tick_out,
  output logic on_fast_out
);

  // switches only on a slow tick boundary so no partial period passes
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      on_fast_out <= 1'b0;
      sys_tick_out <= 1'b0;
    end else begin
      if (slow_tick_in) begin
        on_fast_out <= want_fast_in;
      end
      sys_tick_out <= run_in && (on_fast_out ? fast_tick_in : slow_tick_in);
    end
  end

endmodule : clock_glitch_free_mux

//--- core/power_mode_reset_control.sv
// Contract
// - no halt, fast select and up enable set: normal mode on fast clock
// - no halt, fast select and up enable clear: green mode on slow clock
// - halt with all mode bits clear: sleep, slow oscillator kept, clock stopped
// - halt with oscillator-off set: idle, both oscillators and clock stopped
// - reset, interrupt or enabled port wake leaves sleep or idle to green
// - in idle, timer, clock and dialer interrupts cannot wake
// - each port line selectable as wake; port wake resumes next instruction
// - disabled interrupt or full stack resumes next; else interrupt taken
// - interrupt flag already set at halt cannot wake the device
// - wake inserts 1024 clock delay, then next instruction runs at once
// - interrupt entry follows the start-up delay by one more cycle
// - halt stops clock; watchdog off unless on its own oscillator; here it also runs in sleep when on the slow oscillator
// - halt clears an enabled watchdog; other state kept unchanged
// - halt sets powerdown flag and clears timeout flag
// - power-on, pin low or watchdog time-out resets pc and stack pointer
// - any reset holds execution 1024 clock pulses
// - reset cause recorded in timeout and powerdown flags per table
// - chip reset disables interrupts, clears watchdog, ports input
// - prescale resets to 07 except watchdog time-out while halted
// - port data and direction to ones except halted time-out
// - mode bits 7,6,5 are fast, osc off, up enable; 4..0 read zero
// - halted watchdog time-out is a warm reset of pc and stack only; here it also clears the mode bits 7,6,5
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
module power_mode_reset_control
  import pmr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // core events
  input wire logic halt_in,
  input wire logic [7:0] irq_pending_in,
  input wire logic [7:0] irq_enable_in,
  input wire logic [7:0] irq_slow_src_in,
  input wire logic stack_full_in,
  input wire logic wdog_timeout_in,
  input wire logic external_reset_pin_n_in,
  input wire logic [7:0] wake_port_lines_in,
  input wire logic slow_tick_in,
  input wire logic fast_tick_in,
  input wire logic wdog_on_rc_in,
  input wire logic wdog_on_slow_in,
  // core controls
  output logic core_run_out,
  output logic core_reset_out,
  output logic warm_reset_out,
  output logic irq_take_out,
  output logic sys_tick_out,
  output logic slow_osc_on_out,
  output logic up_conv_on_out,
  output logic on_fast_out,
  output logic wdog_clear_out,
  output logic wdog_run_out,
  output logic [7:0] prescale_out,
  output logic [7:0] port_dir_out,
  output logic [7:0] port_data_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pm_state_t state_r;
  logic fast_sel_r, osc_off_r, up_en_r;
  logic timeout_flag_r, powerdown_flag_r;
  logic [7:0] prescale_r, port_dir_r, port_data_r, wake_mask_r, irq_block_r;
  logic pin_q_r, halted;
  logic ext_rst, wdt_hot, wdt_warm, chip_rst;
  logic wake_port, wake_irq, wake_irq_take, wake_any, take_pending_r;
  logic su_start, su_busy, su_done, irq_take_r;
  logic [7:0] irq_live;
  logic [7:0] bus_idx;
  logic bus_req, bus_wr;
  logic [7:0] rd_data;

  assign halted = (state_r == ST_SLEEP) || (state_r == ST_IDLE);
  assign bus_idx = wb_adr_in[9:2];
  assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign bus_wr = bus_req && wb_we_in && wb_sel_in[0];

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  // pin is sampled each clock; a falling edge starts one chip reset
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_q_r <= 1'b1;
    end else begin
      pin_q_r <= external_reset_pin_n_in;
    end
  end

  assign ext_rst = pin_q_r && !external_reset_pin_n_in;
  assign wdt_hot = wdog_timeout_in && !halted && !ext_rst;
  assign wdt_warm = wdog_timeout_in && halted && !ext_rst;
  assign chip_rst = ext_rst || wdt_hot;

  // ----------------------------------------------------------------
  // wake sources
  // ----------------------------------------------------------------
  // slow-clocked sources are dead in idle; flags set at halt are blocked
  assign irq_live = irq_pending_in & ~irq_block_r
                    & ~((state_r == ST_IDLE) ? irq_slow_src_in : 8'h00);
  assign wake_port = |(wake_port_lines_in & wake_mask_r);
  assign wake_irq = |irq_live;
  assign wake_irq_take = |(irq_live & irq_enable_in) && !stack_full_in;
  assign wake_any = halted && (wake_port || wake_irq);
  assign su_start = wake_any || chip_rst || wdt_warm;

  // flags already pending at halt are latched as non-waking
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_block_r <= 8'h00;
    end else if (halt_in && !halted) begin
      irq_block_r <= irq_pending_in;
    end else if (!halted) begin
      irq_block_r <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= ST_START;
    end else if (su_start) begin
      state_r <= ST_START;
    end else begin
      case (state_r)
        ST_START: begin
          if (su_done) begin
            state_r <= ST_GREEN;
          end
        end
        ST_GREEN, ST_NORMAL: begin
          if (halt_in && !fast_sel_r && !up_en_r) begin
            state_r <= osc_off_r ? ST_IDLE : ST_SLEEP;
          end else if (fast_sel_r && up_en_r) begin
            state_r <= ST_NORMAL;
          end else begin
            state_r <= ST_GREEN;
          end
        end
        ST_SLEEP, ST_IDLE: begin
          state_r <= state_r;
        end
        default: begin
          state_r <= ST_START;
        end
      endcase
    end
  end

  // start-up delay counted on restarted slow oscillator ticks
  startup_counter u_startup (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .start_in(su_start),
    .tick_in(slow_tick_in),
    .busy_out(su_busy),
    .done_out(su_done)
  );

  // glitch-free system tick selection
  clock_glitch_free_mux u_clkmux (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .slow_tick_in(slow_tick_in),
    .fast_tick_in(fast_tick_in),
    .want_fast_in(state_r == ST_NORMAL),
    .run_in((state_r == ST_GREEN) || (state_r == ST_NORMAL)),
    .sys_tick_out(sys_tick_out),
    .on_fast_out(on_fast_out)
  );

  // ----------------------------------------------------------------
  // interrupt entry after wake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      take_pending_r <= 1'b0;
      irq_take_r <= 1'b0;
      irq_take_out <= 1'b0;
    end else begin
      if (chip_rst || wdt_warm) begin
        take_pending_r <= 1'b0;
      end else if (wake_any) begin
        take_pending_r <= wake_irq_take && !wake_port;
      end else if (su_done) begin
        take_pending_r <= 1'b0;
      end
      irq_take_r <= su_done && take_pending_r;
      irq_take_out <= irq_take_r;
    end
  end

  // ----------------------------------------------------------------
  // core run, resets and clocks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      core_run_out <= 1'b0;
      core_reset_out <= 1'b1;
      warm_reset_out <= 1'b0;
      slow_osc_on_out <= 1'b1;
      up_conv_on_out <= 1'b0;
    end else begin
      core_run_out <= !su_busy && !su_start && (state_r != ST_SLEEP)
                      && (state_r != ST_IDLE);
      core_reset_out <= chip_rst;
      warm_reset_out <= wdt_warm;
      slow_osc_on_out <= (state_r != ST_IDLE) || su_start;
      up_conv_on_out <= up_en_r && !halted;
    end
  end

  // watchdog: cleared on halt, running only from a live clock
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wdog_clear_out <= 1'b1;
      wdog_run_out <= 1'b0;
    end else begin
      wdog_clear_out <= (halt_in && !halted) || chip_rst;
      if (!halted) begin
        wdog_run_out <= 1'b1;
      end else begin
        wdog_run_out <= wdog_on_rc_in
                        || (wdog_on_slow_in && state_r == ST_SLEEP);
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      timeout_flag_r <= 1'b0;
      powerdown_flag_r <= 1'b0;
    end else if (wdog_timeout_in && !ext_rst) begin
      timeout_flag_r <= 1'b1;
      if (halted) begin
        powerdown_flag_r <= 1'b1;
      end
    end else if (ext_rst && halted) begin
      timeout_flag_r <= 1'b0;
      powerdown_flag_r <= 1'b1;
    end else if (halt_in && !halted) begin
      timeout_flag_r <= 1'b0;
      powerdown_flag_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fast_sel_r <= MODE_CTRL_RST[FAST_CLK_BIT];
      osc_off_r <= MODE_CTRL_RST[OSC_OFF_BIT];
      up_en_r <= MODE_CTRL_RST[UP_EN_BIT];
    end else if (wdt_warm) begin
      fast_sel_r <= 1'b0;
      osc_off_r <= 1'b0;
      up_en_r <= 1'b0;
    end else if (chip_rst) begin
      fast_sel_r <= 1'b0;
      osc_off_r <= 1'b0;
    end else if (bus_wr && bus_idx == MODE_CTRL_IDX) begin
      fast_sel_r <= wb_dat_in[FAST_CLK_BIT];
      osc_off_r <= wb_dat_in[OSC_OFF_BIT];
      up_en_r <= wb_dat_in[UP_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // prescale, port and wake mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prescale_r <= WDOG_PRESCALE_RST;
      port_dir_r <= PORT_RST;
      port_data_r <= PORT_RST;
    end else if (chip_rst) begin
      prescale_r <= WDOG_PRESCALE_RST;
      port_dir_r <= PORT_RST;
      port_data_r <= PORT_RST;
    end else if (bus_wr && !wdt_warm) begin
      if (bus_idx == WDOG_PRESCALE_IDX) begin
        prescale_r <= wb_dat_in[7:0];
      end
      if (bus_idx == PORT_DIR_IDX) begin
        port_dir_r <= wb_dat_in[7:0];
      end
      if (bus_idx == PORT_DATA_IDX) begin
        port_data_r <= wb_dat_in[7:0];
      end
    end
  end

  // wake mask stands in for the fixed build option
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wake_mask_r <= WAKE_MASK_RST;
    end else if (bus_wr && bus_idx == WAKE_CTRL_IDX) begin
      wake_mask_r <= wb_dat_in[7:0];
    end
  end

  assign prescale_out = prescale_r;
  assign port_dir_out = port_dir_r;
  assign port_data_out = port_data_r;

  // ----------------------------------------------------------------
  // wishbone read and ack
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00;
    case (bus_idx)
      WDOG_PRESCALE_IDX: rd_data = prescale_r;
      PROC_STATUS_IDX: begin
        rd_data[TIMEOUT_BIT] = timeout_flag_r;
        rd_data[PWRDN_BIT] = powerdown_flag_r;
      end
      MODE_CTRL_IDX: rd_data = {fast_sel_r, osc_off_r, up_en_r, 5'h00};
      PORT_DATA_IDX: rd_data = port_data_r;
      PORT_DIR_IDX: rd_data = port_dir_r;
      WAKE_CTRL_IDX: rd_data = wake_mask_r;
      CORE_STAT_IDX: rd_data = {5'h00, state_r};
      default: rd_data = 8'h00;
    endcase
  end

  // one wait-free ack one cycle after the request
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req;
      wb_dat_out <= bus_req ? {24'h00_0000, rd_data} : 32'h0000_0000;
    end
  end

endmodule : power_mode_reset_control

//--- verif/pmr_asserts.sv
`timescale 1ns/1ps
module pmr_asserts
  import pmr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // bus
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  // events and controls
  input wire logic halt_in,
  input wire logic slow_tick_in,
  input wire logic core_run_out,
  input wire logic core_reset_out,
  input wire logic warm_reset_out,
  input wire logic irq_take_out,
  input wire logic sys_tick_out,
  input wire logic slow_osc_on_out,
  input wire logic up_conv_on_out,
  input wire logic on_fast_out,
  input wire logic wdog_clear_out,
  input wire logic [7:0] prescale_out,
  input wire logic [7:0] port_dir_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [11:0] tick_r;
  // slow ticks seen since the core last ran
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_r <= '0;
    end else if (core_run_out) begin
      tick_r <= '0;
    end else if (slow_tick_in && tick_r != 12'hfff) begin
      tick_r <= tick_r + 12'h001;
    end
  end
  sequence req_s;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence ack_s;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  sequence quiet_halt_s;
    halt_in && core_run_out && !on_fast_out && !up_conv_on_out;
  endsequence
  bus_ack_a: assert property (req_s |=> ack_s)
    else $error("ack missing or too long");
  mode_read_a: assert property (wb_ack_out && !$past(wb_we_in) &&
    $past(wb_adr_in[9:2]) == MODE_CTRL_IDX |-> (wb_dat_out & 32'hffffff1f) == '0)
    else $error("mode read shows reserved bits");
  // run and tick are registered off the mode state, so they drop one cycle after entry
  halt_stop_a: assert property (quiet_halt_s |=> ##1
    (!core_run_out && !sys_tick_out)[*8])
    else $error("halt did not stop the core clock");
  halt_clr_a: assert property (halt_in && core_run_out |=> wdog_clear_out)
    else $error("halt did not clear the watchdog");
  idle_osc_a: assert property (!slow_osc_on_out |-> !up_conv_on_out && !core_run_out)
    else $error("oscillator off while still running");
  normal_osc_a: assert property (on_fast_out |-> up_conv_on_out && slow_osc_on_out)
    else $error("fast clock without both sources");
  warm_keep_a: assert property (warm_reset_out |=> $stable(prescale_out)
    && $stable(port_dir_out))
    else $error("warm reset changed registers");
  warm_only_a: assert property (warm_reset_out |-> !core_reset_out)
    else $error("warm reset raised chip reset");
  chip_rst_a: assert property (core_reset_out |-> ##[0:2]
    prescale_out == WDOG_PRESCALE_RST && port_dir_out == PORT_RST)
    else $error("chip reset left registers");
  irq_late_a: assert property ($rose(core_run_out) |-> !irq_take_out)
    else $error("interrupt taken with release");
  startup_a: assert property ($rose(core_run_out) |-> tick_r >= STARTUP_CYCLES)
    else $error("core released before start-up count");
endmodule : pmr_asserts
bind power_mode_reset_control pmr_asserts chk_i (.*);

//--- verif/core_model.sv
`timescale 1ns/1ps
module core_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // device state
  input wire logic slow_osc_on_in,
  input wire logic up_conv_on_in,
  input wire logic core_run_in,
  input wire logic halt_req_in,
  // to device
  output logic slow_tick_out,
  output logic fast_tick_out,
  output logic halt_out
);
  logic div_r;
  // sources tick only while their oscillator runs; halt only from a running core
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_r <= 1'b0;
      slow_tick_out <= 1'b0;
      fast_tick_out <= 1'b0;
      halt_out <= 1'b0;
    end else begin
      div_r <= ~div_r;
      slow_tick_out <= slow_osc_on_in && div_r;
      fast_tick_out <= up_conv_on_in;
      halt_out <= halt_req_in && core_run_in && !halt_out;
    end
  end
endmodule : core_model

//--- verif/test_power_mode_reset_control.sv
`timescale 1ns/1ps
module test_power_mode_reset_control
  import pmr_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  localparam int SETTLE = 40; // up-converter settle, shortened
  logic clk_in = 0, arst_n_in = 0, cyc = 0, stb = 0, we = 0, hreq = 0, sfull = 0;
  logic wto = 0, pin_n = 1, got, rc = 1, sl = 0;
  logic [9:0] adr = '0;
  logic [31:0] wdat = '0, rdat;
  logic [7:0] pend = '0, en = '0, ssrc = '0, wake = '0, d;
  wire logic st_w, ft_w, halt, ack, run, take, s_on, u_on, f_on, wrun;
  wire logic [31:0] rd_w;
  wire logic [7:0] pdat;
  int fail_count = 0, checks = 0, cyc_cnt = 0, n;
  always #50 clk_in = ~clk_in;
  core_model core_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .slow_osc_on_in(s_on),
    .up_conv_on_in(u_on), .core_run_in(run), .halt_req_in(hreq), .slow_tick_out(st_w),
    .fast_tick_out(ft_w), .halt_out(halt));
  power_mode_reset_control dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat),
    .wb_dat_out(rd_w), .wb_ack_out(ack), .halt_in(halt), .irq_pending_in(pend),
    .irq_enable_in(en), .irq_slow_src_in(ssrc), .stack_full_in(sfull),
    .wdog_timeout_in(wto), .external_reset_pin_n_in(pin_n), .wake_port_lines_in(wake),
    .slow_tick_in(st_w), .fast_tick_in(ft_w), .wdog_on_rc_in(rc),
    .wdog_on_slow_in(sl), .core_run_out(run), .core_reset_out(), .warm_reset_out(),
    .irq_take_out(take), .sys_tick_out(), .slow_osc_on_out(s_on), .up_conv_on_out(u_on),
    .on_fast_out(f_on), .wdog_clear_out(), .wdog_run_out(wrun), .prescale_out(),
    .port_dir_out(), .port_data_out(pdat));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] mode_exp(input logic [7:0] v);
    return {v[7:5], 5'h00};
  endfunction : mode_exp
  function automatic logic in_win(input int c);
    return c >= 2 * STARTUP_CYCLES - 4 && c <= 2 * STARTUP_CYCLES + 16;
  endfunction : in_win
  task automatic results;
    $display("checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] v);
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h000000, v};
    do @(posedge clk_in); while (ack !== 1'b1);
    rdat = rd_w;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(rdat, {24'h000000, e});
  endtask : rd
  task automatic st(input logic t, input logic p);
    bus(1'b0, PROC_STATUS_IDX, 8'h00);
    chk(32'(rdat[5:4]), 32'({t, p}));
  endtask : st
  task automatic cyc_wait(input int k);
    repeat (k) @(posedge clk_in);
  endtask : cyc_wait
  task automatic halt_now;
    hreq <= 1'b1;
    @(posedge clk_in);
    hreq <= 1'b0;
    cyc_wait(10);
  endtask : halt_now
  task automatic wait_run;
    n = 0;
    while (run !== 1'b1) begin
      @(posedge clk_in);
      n++;
    end
  endtask : wait_run
  // hang guard
  always @(posedge clk_in) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      fail_count++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(17862));
    cyc_wait(12);
    arst_n_in <= 1'b1;
    wait_run();
    chk(32'(in_win(n)), 32'h1);
    rd(WDOG_PRESCALE_IDX, WDOG_PRESCALE_RST);
    rd(MODE_CTRL_IDX, MODE_CTRL_RST);
    rd(PORT_DATA_IDX, PORT_RST);
    rd(PORT_DIR_IDX, PORT_RST);
    st(1'b0, 1'b0);
    rd(8'h3f, 8'h00);
    repeat (4) begin
      d = 8'($urandom) & 8'h7f;
      bus(1'b1, MODE_CTRL_IDX, d);
      rd(MODE_CTRL_IDX, mode_exp(d));
      d = 8'($urandom);
      bus(1'b1, WDOG_PRESCALE_IDX, d);
      rd(WDOG_PRESCALE_IDX, d);
    end
    bus(1'b1, MODE_CTRL_IDX, 8'h20);
    cyc_wait(SETTLE);
    bus(1'b1, MODE_CTRL_IDX, 8'ha0);
    cyc_wait(20);
    chk(32'({f_on, u_on, s_on}), 32'h7);
    bus(1'b1, MODE_CTRL_IDX, 8'h20);
    cyc_wait(20);
    bus(1'b1, MODE_CTRL_IDX, 8'h00);
    cyc_wait(20);
    chk(32'({f_on, u_on, s_on}), 32'h1);
    // sleep with a stale flag, then a port wake
    bus(1'b1, WAKE_CTRL_IDX, 8'h01);
    bus(1'b1, PORT_DATA_IDX, 8'h5a);
    pend <= 8'h02;
    en <= 8'h02;
    rc <= 1'b0;
    sl <= 1'b1;
    halt_now();
    cyc_wait(40);
    rd(CORE_STAT_IDX, 8'h02);
    chk(32'({s_on, u_on, wrun}), 32'h5);
    st(1'b0, 1'b1);
    pend <= 8'h00;
    wake <= 8'h01;
    wait_run();
    wake <= 8'h00;
    chk(32'(in_win(n)), 32'h1);
    rd(PORT_DATA_IDX, 8'h5a);
    // idle: slow sources dead, then full and free stack
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, MODE_CTRL_IDX, 8'h40);
      rc <= (k == 0);
      halt_now();
      sfull <= (k == 0);
      ssrc <= 8'h04;
      pend <= 8'h04;
      en <= 8'h0c;
      cyc_wait(40);
      rd(CORE_STAT_IDX, 8'h03);
      chk(32'(wrun), 32'(k == 0));
      pend <= 8'h0c;
      wait_run();
      got = 1'b0;
      repeat (6) begin
        @(posedge clk_in);
        got = got | take;
      end
      chk(32'(got), 32'(k));
      pend <= 8'h00;
      ssrc <= 8'h00;
      rc <= 1'b1;
    end
    // watchdog time-out while running
    bus(1'b1, MODE_CTRL_IDX, 8'h20);
    bus(1'b1, WDOG_PRESCALE_IDX, 8'h55);
    wto <= 1'b1;
    @(posedge clk_in);
    wto <= 1'b0;
    cyc_wait(4);
    wait_run();
    st(1'b1, 1'b1);
    rd(MODE_CTRL_IDX, 8'h20);
    rd(WDOG_PRESCALE_IDX, WDOG_PRESCALE_RST);
    rd(PORT_DATA_IDX, PORT_RST);
    // watchdog time-out while halted
    bus(1'b1, MODE_CTRL_IDX, 8'h40);
    bus(1'b1, WDOG_PRESCALE_IDX, 8'h3c);
    bus(1'b1, PORT_DATA_IDX, 8'h5a);
    halt_now();
    wto <= 1'b1;
    @(posedge clk_in);
    wto <= 1'b0;
    cyc_wait(4);
    wait_run();
    st(1'b1, 1'b1);
    rd(WDOG_PRESCALE_IDX, 8'h3c);
    rd(PORT_DATA_IDX, 8'h5a);
    rd(MODE_CTRL_IDX, 8'h00);
    // pin reset while halted
    halt_now();
    pin_n <= 1'b0;
    cyc_wait(2);
    pin_n <= 1'b1;
    cyc_wait(4);
    wait_run();
    st(1'b0, 1'b1);
    rd(PORT_DATA_IDX, PORT_RST);
    rd(WDOG_PRESCALE_IDX, WDOG_PRESCALE_RST);
    chk(32'(pdat), 32'(PORT_RST));
    results();
  end
endmodule : test_power_mode_reset_control
